// ===== core/icar_consts.svh
// Constants for the I/O configuration access router
// What this block does
// - Address port at 0CF8h, dword only, resets zero
// - Narrow address-port access forwarded downstream as I/O
// - Bit 31 enables configuration, resets to zero
// - Bus zero, non-internal device: link Type 0
// - Bus outside bridge ranges: link Type 1
// - Bus equals bridge secondary: express Type 0
// - Bus within secondary..subordinate: express Type 1
// - Bus goes to header byte 5, A[23:16]
// - Device field 15:11; devices 0,1,3 internal
// - Device to header byte 6 [7:3], A[15:11]
// - Function 10:8; internal nonzero function ignored
// - Function to header byte 6 [2:0], A[10:8]
// - Register 7:2 to header byte 7, A[7:2]
// - Data port 0CFCh, 32-bit window, resets zero
// - Enabled data access makes configuration transaction
// - Express Type 0 to nonzero device aborts
`ifndef ICAR_CONSTS_SVH
`define ICAR_CONSTS_SVH
`define ICAR_ADDR_PORT      16'h0CF8
`define ICAR_DATA_PORT      16'h0CFC
`define ICAR_ADDR_RESET     32'h0000_0000
`define ICAR_DATA_RESET     32'h0000_0000
`define ICAR_ENABLE_BIT     31
`define ICAR_BUS_HI         23
`define ICAR_BUS_LO         16
`define ICAR_DEV_HI         15
`define ICAR_DEV_LO         11
`define ICAR_FUN_HI         10
`define ICAR_FUN_LO         8
`define ICAR_REG_HI         7
`define ICAR_REG_LO         2
`define ICAR_ADDR_WMASK     32'h80FF_FFFC
`define ICAR_DEV_HOST       5'h00
`define ICAR_DEV_PEG        5'h01
`define ICAR_DEV_PEG2       5'h03
`define ICAR_BE_FULL        4'hF
`endif

// ===== core/icar_pkg.sv
// Types for the I/O configuration access router
package icar_pkg;
    typedef enum logic [2:0] {
        ICAR_TGT_NONE,
        ICAR_TGT_INTERNAL,
        ICAR_TGT_LINK_IO,
        ICAR_TGT_LINK_T0,
        ICAR_TGT_LINK_T1,
        ICAR_TGT_PEX_T0,
        ICAR_TGT_PEX_T1,
        ICAR_TGT_ABORT
    } icar_target_e;
endpackage : icar_pkg

// ===== core/icar_route_decode.sv
// Combinational route decode for one configuration address
`timescale 1ns/1ps
`include "icar_consts.svh"
module icar_route_decode (
    // Selected address
    input  wire logic [7:0] bus_i,
    input  wire logic [4:0] dev_i,
    input  wire logic [2:0] fun_i,
    // Bridge windows
    input  wire logic [7:0] sec1_i,
    input  wire logic [7:0] sub1_i,
    input  wire logic [7:0] sec3_i,
    input  wire logic [7:0] sub3_i,
    input  wire logic       en1_i,
    input  wire logic       en3_i,
    // Result
    output icar_pkg::icar_target_e target_o
);
    function automatic logic in_win(input logic [7:0] b, input logic [7:0] lo,
                                    input logic [7:0] hi, input logic en);
        in_win = en && (b >= lo) && (b <= hi);
    endfunction : in_win

    logic hit1;
    logic hit3;
    logic sec_hit;
    assign hit1    = in_win(bus_i, sec1_i, sub1_i, en1_i);
    assign hit3    = in_win(bus_i, sec3_i, sub3_i, en3_i);
    assign sec_hit = (en1_i && bus_i == sec1_i) || (en3_i && bus_i == sec3_i);

    always_comb begin
        if (bus_i == 8'h00) begin
            if (dev_i == `ICAR_DEV_HOST || dev_i == `ICAR_DEV_PEG ||
                dev_i == `ICAR_DEV_PEG2) begin
                target_o = (fun_i == 3'h0) ? icar_pkg::ICAR_TGT_INTERNAL
                                           : icar_pkg::ICAR_TGT_NONE;
            end else begin
                target_o = icar_pkg::ICAR_TGT_LINK_T0;
            end
        end else if (sec_hit) begin
            target_o = (dev_i == 5'h00) ? icar_pkg::ICAR_TGT_PEX_T0
                                        : icar_pkg::ICAR_TGT_ABORT;
        end else if (hit1 || hit3) begin
            target_o = icar_pkg::ICAR_TGT_PEX_T1;
        end else begin
            target_o = icar_pkg::ICAR_TGT_LINK_T1;
        end
    end
endmodule : icar_route_decode

// ===== core/icar_router.sv
// I/O configuration access router: address/data ports and request steering
`timescale 1ns/1ps
`include "icar_consts.svh"
module icar_router (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // Host I/O port cycle
    input  wire logic        io_req_i,
    input  wire logic        io_wr_i,
    input  wire logic [15:0] io_addr_i,
    input  wire logic [3:0]  io_be_i,
    input  wire logic [31:0] io_wdata_i,
    output logic             io_done_o,
    output logic [31:0]      io_rdata_o,
    output logic             io_abort_o,
    // Bridge bus windows from internal bridges
    input  wire logic [7:0]  sec1_i,
    input  wire logic [7:0]  sub1_i,
    input  wire logic [7:0]  sec3_i,
    input  wire logic [7:0]  sub3_i,
    input  wire logic        en1_i,
    input  wire logic        en3_i,
    // Downstream request (internal, link or express)
    output logic             req_valid_o,
    output icar_pkg::icar_target_e req_target_o,
    output logic             req_wr_o,
    output logic [3:0]       req_be_o,
    output logic [31:0]      req_addr_o,
    output logic [31:0]      req_hdr_o,
    output logic [31:0]      req_wdata_o,
    input  wire logic        req_done_i,
    input  wire logic [31:0] req_rdata_i,
    // State
    output logic             config_enable_bit_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} icar_state_e;

    icar_state_e state_reg, state_next;
    logic [31:0] addr_reg, addr_next;
    logic [31:0] data_reg, data_next;
    logic        done_reg, done_next;
    logic        abort_reg, abort_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        rv_reg, rv_next;
    icar_pkg::icar_target_e tgt_reg, tgt_next;
    logic        wr_reg, wr_next;
    logic [3:0]  be_reg, be_next;
    logic [31:0] raddr_reg, raddr_next;
    logic [31:0] hdr_reg, hdr_next;
    logic [31:0] wd_reg, wd_next;

    icar_pkg::icar_target_e route;
    logic [7:0] bus_f;
    logic [4:0] dev_f;
    logic [2:0] fun_f;
    logic [5:0] reg_f;
    logic       hit_addr;
    logic       hit_data;
    logic       enabled;

    assign bus_f    = addr_reg[`ICAR_BUS_HI:`ICAR_BUS_LO];
    assign dev_f    = addr_reg[`ICAR_DEV_HI:`ICAR_DEV_LO];
    assign fun_f    = addr_reg[`ICAR_FUN_HI:`ICAR_FUN_LO];
    assign reg_f    = addr_reg[`ICAR_REG_HI:`ICAR_REG_LO];
    assign enabled  = addr_reg[`ICAR_ENABLE_BIT];
    assign hit_addr = {io_addr_i[15:2], 2'b00} == `ICAR_ADDR_PORT;
    assign hit_data = {io_addr_i[15:2], 2'b00} == `ICAR_DATA_PORT;

    icar_route_decode u_decode (
        .bus_i    (bus_f),
        .dev_i    (dev_f),
        .fun_i    (fun_f),
        .sec1_i   (sec1_i),
        .sub1_i   (sub1_i),
        .sec3_i   (sec3_i),
        .sub3_i   (sub3_i),
        .en1_i    (en1_i),
        .en3_i    (en3_i),
        .target_o (route)
    );

    always_comb begin
        state_next = state_reg;
        addr_next  = addr_reg;
        data_next  = data_reg;
        done_next  = 1'b0;
        abort_next = 1'b0;
        rdata_next = rdata_reg;
        rv_next    = 1'b0;
        tgt_next   = tgt_reg;
        wr_next    = wr_reg;
        be_next    = be_reg;
        raddr_next = raddr_reg;
        hdr_next   = hdr_reg;
        wd_next    = wd_reg;
        case (state_reg)
            ST_IDLE: begin
                if (io_req_i) begin
                    wr_next    = io_wr_i;
                    be_next    = io_be_i;
                    wd_next    = io_wdata_i;
                    raddr_next = {16'h0000, io_addr_i};
                    hdr_next   = 32'h0000_0000;
                    if (hit_addr && io_be_i == `ICAR_BE_FULL) begin
                        // Only full dword accesses reach the address port
                        if (io_wr_i) begin
                            addr_next = io_wdata_i & `ICAR_ADDR_WMASK;
                        end
                        rdata_next = io_wr_i ? rdata_reg : addr_reg;
                        done_next  = 1'b1;
                        state_next = ST_DONE;
                    end else if (hit_data && enabled) begin
                        // Configuration transaction from the address port
                        tgt_next   = route;
                        raddr_next = {8'h00, bus_f, dev_f, fun_f, reg_f, 2'b00};
                        hdr_next   = {bus_f, dev_f, fun_f, reg_f, 2'b00, 8'h00};
                        if (io_wr_i) begin
                            data_next = io_wdata_i;
                        end
                        if (route == icar_pkg::ICAR_TGT_NONE) begin
                            rdata_next = 32'hFFFF_FFFF;
                            done_next  = 1'b1;
                            state_next = ST_DONE;
                        end else if (route == icar_pkg::ICAR_TGT_ABORT) begin
                            rdata_next = 32'hFFFF_FFFF;
                            abort_next = 1'b1;
                            done_next  = 1'b1;
                            state_next = ST_DONE;
                        end else begin
                            rv_next    = 1'b1;
                            state_next = ST_WAIT;
                        end
                    end else begin
                        tgt_next   = icar_pkg::ICAR_TGT_LINK_IO;
                        rv_next    = 1'b1;
                        state_next = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                rv_next = 1'b1;
                if (req_done_i) begin
                    rv_next    = 1'b0;
                    rdata_next = req_rdata_i;
                    if (!wr_reg && tgt_reg != icar_pkg::ICAR_TGT_LINK_IO) begin
                        data_next = req_rdata_i;
                    end
                    done_next  = 1'b1;
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            addr_reg  <= `ICAR_ADDR_RESET;
            data_reg  <= `ICAR_DATA_RESET;
            done_reg  <= 1'b0;
            abort_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rv_reg    <= 1'b0;
            tgt_reg   <= icar_pkg::ICAR_TGT_LINK_IO;
            wr_reg    <= 1'b0;
            be_reg    <= 4'h0;
            raddr_reg <= 32'h0000_0000;
            hdr_reg   <= 32'h0000_0000;
            wd_reg    <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            addr_reg  <= addr_next;
            data_reg  <= data_next;
            done_reg  <= done_next;
            abort_reg <= abort_next;
            rdata_reg <= rdata_next;
            rv_reg    <= rv_next;
            tgt_reg   <= tgt_next;
            wr_reg    <= wr_next;
            be_reg    <= be_next;
            raddr_reg <= raddr_next;
            hdr_reg   <= hdr_next;
            wd_reg    <= wd_next;
        end
    end

    assign io_done_o           = done_reg;
    assign io_rdata_o          = rdata_reg;
    assign io_abort_o          = abort_reg;
    assign req_valid_o         = rv_reg;
    assign req_target_o        = tgt_reg;
    assign req_wr_o            = wr_reg;
    assign req_be_o            = be_reg;
    assign req_addr_o          = raddr_reg;
    assign req_hdr_o           = hdr_reg;
    assign req_wdata_o         = wd_reg;
    assign config_enable_bit_o = addr_reg[`ICAR_ENABLE_BIT];
endmodule : icar_router

// ===== testbench/icar_router_asserts.sv
// Port assertions for the configuration access router
`timescale 1ns/1ps
module icar_router_asserts (
    // Clock, reset and host cycle
    input wire logic        mclk_i, rst_i, io_req_i, io_wr_i, io_done_o, io_abort_o,
    input wire logic [15:0] io_addr_i,
    input wire logic [3:0]  io_be_i,
    input wire logic [31:0] io_wdata_i, io_rdata_o,
    // Downstream request
    input wire logic        req_valid_o, req_done_i, config_enable_bit_o,
    input wire logic [31:0] req_addr_o, req_hdr_o,
    input icar_pkg::icar_target_e req_target_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    wire take = io_req_i && !req_valid_o && !io_done_o;
    wire ap   = io_addr_i[15:2] == 14'h033E;
    wire dp   = io_addr_i[15:2] == 14'h033F;
    a_enable_write: assert property (take && ap && io_wr_i && io_be_i == 4'hF |=>
        io_done_o && config_enable_bit_o == $past(io_wdata_i[31])) else $error("enable write");
    a_narrow_pass: assert property (take && ap && io_be_i != 4'hF |=> !io_done_o &&
        req_valid_o && req_target_o == icar_pkg::ICAR_TGT_LINK_IO) else $error("narrow");
    a_disabled_io: assert property (take && dp && !config_enable_bit_o |=>
        req_valid_o && req_target_o == icar_pkg::ICAR_TGT_LINK_IO) else $error("disabled");
    a_enabled_cfg: assert property (take && dp && config_enable_bit_o |=> io_done_o ||
        req_valid_o && req_target_o != icar_pkg::ICAR_TGT_LINK_IO) else $error("enabled");
    a_done_after: assert property (req_valid_o && req_done_i |=>
        io_done_o && !req_valid_o) else $error("completion");
    a_abort_ones: assert property (io_abort_o |-> io_done_o &&
        io_rdata_o == 32'hFFFF_FFFF) else $error("abort data");
    a_hdr_fields: assert property (req_valid_o && req_target_o >= icar_pkg::ICAR_TGT_LINK_T0
        && req_target_o <= icar_pkg::ICAR_TGT_PEX_T1 |-> req_hdr_o[31:16] == req_addr_o[23:8]
        && req_hdr_o[15:10] == req_addr_o[7:2]) else $error("header fields");
    a_link_bus: assert property (req_valid_o && req_target_o == icar_pkg::ICAR_TGT_LINK_T0
        |-> req_addr_o[23:16] == 8'h00) else $error("link bus");
    a_req_holds: assert property (req_valid_o && !req_done_i |=>
        req_valid_o && $stable(req_addr_o)) else $error("request dropped");
endmodule : icar_router_asserts
bind icar_router icar_router_asserts i_chk (.mclk_i, .rst_i, .io_req_i, .io_wr_i, .io_done_o,
    .io_abort_o, .io_addr_i, .io_be_i, .io_wdata_i, .io_rdata_o, .req_valid_o, .req_done_i,
    .config_enable_bit_o, .req_addr_o, .req_hdr_o, .req_target_o);

// ===== testbench/icar_target_model.sv
// Downstream target model answering requests after a random wait
`timescale 1ns/1ps
module icar_target_model (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // Request side
    input  wire logic        req_valid_o,
    input  wire logic [31:0] req_addr_o,
    output logic             req_done_i,
    output logic [31:0]      req_rdata_i
);
    int wait_cnt = 0;
    initial begin
        req_done_i  = 1'b0;
        req_rdata_i = 32'h0;
    end
    always @(negedge mclk_i) begin
        req_done_i  <= 1'b0;
        // Data is junk outside a completion
        req_rdata_i <= $urandom;
        if (rst_i) wait_cnt <= 0;
        else if (req_valid_o && !req_done_i) begin
            if (wait_cnt == 0) begin
                req_done_i  <= 1'b1;
                req_rdata_i <= ~req_addr_o;
                wait_cnt    <= $urandom_range(4, 0);
            end else wait_cnt <= wait_cnt - 1;
        end
    end
endmodule : icar_target_model

// ===== testbench/tb_top.sv
// Self-checking bench for the configuration access router
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [2:0]             c;
        icar_pkg::icar_target_e t;
        logic [31:0]            d;
    } icar_tb_note_s;
    logic        mclk_i = 0, rst_i = 1, io_req_i = 0, io_wr_i = 0, en1_i = 1, en3_i = 1;
    logic [15:0] io_addr_i = 16'h0;
    logic [3:0]  io_be_i = 4'h0, req_be_o;
    logic [7:0]  sec1_i = 8'h02, sub1_i = 8'h05, sec3_i = 8'h08, sub3_i = 8'h08, rg;
    logic [31:0] io_wdata_i = 32'h0, req_rdata_i, io_rdata_o, req_addr_o, req_hdr_o, req_wdata_o;
    logic        io_done_o, io_abort_o, req_valid_o, req_wr_o, req_done_i, config_enable_bit_o;
    logic [31:0] r;
    icar_pkg::icar_target_e req_target_o;
    icar_tb_note_s q[$];
    icar_tb_note_s n;
    int failures = 0, num_checks = 0, cyc = 0;
    icar_router i_dut (.mclk_i, .rst_i, .io_req_i, .io_wr_i, .io_addr_i, .io_be_i, .io_wdata_i,
        .io_done_o, .io_rdata_o, .io_abort_o, .sec1_i, .sub1_i, .sec3_i, .sub3_i, .en1_i, .en3_i,
        .req_valid_o, .req_target_o, .req_wr_o, .req_be_o, .req_addr_o, .req_hdr_o,
        .req_wdata_o, .req_done_i, .req_rdata_i, .config_enable_bit_o);
    icar_target_model i_tgt (.mclk_i, .rst_i, .req_valid_o, .req_addr_o, .req_done_i,
        .req_rdata_i);
    initial forever #2.5 mclk_i = ~mclk_i;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            end_of_test();
        end
    end
    // Note format c: check abort, target, read data
    task automatic io(input logic w, input logic [15:0] a, input logic [3:0] be,
        input logic [31:0] d, input logic [2:0] c, input icar_pkg::icar_target_e t,
        input logic [31:0] e);
        q.push_back('{c, t, e});
        @(negedge mclk_i);
        {io_req_i, io_wr_i, io_addr_i, io_be_i, io_wdata_i} = {1'b1, w, a, be, d};
        do @(negedge mclk_i); while (io_done_o !== 1'b1);
        io_req_i = 1'b0;
    endtask : io
    task automatic cfg(input logic [31:0] a, input icar_pkg::icar_target_e t,
        input logic [2:0] c);
        io(1'b1, 16'h0CF8, 4'hF, a, 3'b000, t, 32'h0);
        io(1'b0, 16'h0CFC, 4'hF, 32'h0, c, t, c[1] ? ~{8'h00, a[23:2], 2'b00} : 32'hFFFF_FFFF);
    endtask : cfg
    always @(negedge mclk_i) begin
        if (io_done_o === 1'b1) begin
            n = q.pop_front();
            chk({31'h0, io_abort_o}, {31'h0, n.c[2]});
            if (n.c[1]) chk({29'h0, req_target_o}, {29'h0, n.t});
            if (n.c[0]) chk(io_rdata_o, n.d);
        end
    end
    initial begin
        void'($urandom(32'hEBF3942E));
        sec1_i = 8'($urandom_range(64, 1));
        sub1_i = sec1_i + 8'h03;
        sec3_i = sub1_i + 8'h10;
        sub3_i = sec3_i;
        rg = 8'($urandom) & 8'hFC;
        r = $urandom;
        repeat (12) @(negedge mclk_i);
        rst_i = 1'b0;
        chk({31'h0, config_enable_bit_o}, 32'h0);
        io(1'b0, 16'h0CF8, 4'hF, 0, 3'b001, icar_pkg::ICAR_TGT_LINK_IO, 32'h0);
        io(1'b0, 16'h0CFC, 4'hF, 0, 3'b011, icar_pkg::ICAR_TGT_LINK_IO, ~32'h0CFC);
        io(1'b1, 16'h0CFA, 4'h3, r, 3'b010, icar_pkg::ICAR_TGT_LINK_IO, 0);
        chk({28'h0, req_be_o}, 32'h0000_0003);
        chk(req_addr_o, 32'h0000_0CFA);
        chk(req_wdata_o, r);
        io(1'b0, 16'h0CF8, 4'hF, 0, 3'b001, icar_pkg::ICAR_TGT_LINK_IO, 32'h0);
        io(1'b1, 16'h0CF8, 4'hF, r, 3'b000, icar_pkg::ICAR_TGT_LINK_IO, 0);
        io(1'b0, 16'h0CF8, 4'hF, 0, 3'b001, icar_pkg::ICAR_TGT_LINK_IO, r & 32'h80FF_FFFC);
        $display("test register ports done");
        cfg({8'h80, 8'h00, 5'h01, 3'h0, rg}, icar_pkg::ICAR_TGT_INTERNAL, 3'b011);
        cfg({8'h80, 8'h00, 5'h03, 3'h2, rg}, icar_pkg::ICAR_TGT_INTERNAL, 3'b001);
        cfg({8'h80, 8'h00, 5'h05, 3'h1, rg}, icar_pkg::ICAR_TGT_LINK_T0, 3'b011);
        io(1'b1, 16'h0CFC, 4'hF, ~r, 3'b010, icar_pkg::ICAR_TGT_LINK_T0, 0);
        chk(req_wdata_o, ~r);
        chk({31'h0, req_wr_o}, 32'h1);
        chk({28'h0, req_be_o}, 32'h0000_000F);
        chk(req_addr_o, {8'h00, 8'h00, 5'h05, 3'h1, rg});
        cfg({8'h80, 8'hF0, 5'h07, 3'h3, rg}, icar_pkg::ICAR_TGT_LINK_T1, 3'b011);
        cfg({8'h80, sec1_i, 5'h00, 3'h4, rg}, icar_pkg::ICAR_TGT_PEX_T0, 3'b011);
        cfg({8'h80, sec1_i, 5'h02, 3'h0, rg}, icar_pkg::ICAR_TGT_ABORT, 3'b101);
        cfg({8'h80, sub1_i, 5'h09, 3'h5, rg}, icar_pkg::ICAR_TGT_PEX_T1, 3'b011);
        cfg({8'h80, sec3_i, 5'h00, 3'h6, rg}, icar_pkg::ICAR_TGT_PEX_T0, 3'b011);
        en3_i = 1'b0;
        cfg({8'h80, sec3_i, 5'h00, 3'h7, rg}, icar_pkg::ICAR_TGT_LINK_T1, 3'b011);
        $display("test routing done");
        end_of_test();
    end
endmodule : tb_top
